// ---- tco_pkg.sv ----
// Purpose: constants for the timer channel output control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses
package tco_pkg;
	localparam int ADDR_W = 12;
	localparam int DT_W = 8;
	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_MODE = 12'h01c;
	localparam logic [ADDR_W-1:0] OFF_ENPOL = 12'h020;
	localparam logic [ADDR_W-1:0] OFF_BRK = 12'h044;
	localparam logic [ADDR_W-1:0] OFF_TRIG = 12'h048;
	localparam logic [ADDR_W-1:0] OFF_STAT = 12'h04c;
	// reset values
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] ENPOL_RST = 16'h0000;
	localparam logic [31:0] BRK_RST = 32'h0000_0000;
	localparam logic [2:0] TRIG_RST = 3'h0;
	// channel pair mode fields
	localparam int MODE_C2DIR_LSB = 0;
	localparam int MODE_C3DIR_LSB = 8;
	// enable/polarity fields, channel n at bit ENPOL_STRIDE*n + pos
	localparam int ENPOL_STRIDE = 4;
	localparam int ENPOL_EN_POS = 0;
	localparam int ENPOL_POL_POS = 1;
	localparam int ENPOL_CEN_POS = 2;
	localparam int ENPOL_CPOL_POS = 3;
	localparam logic [15:0] ENPOL_USED_MASK = 16'hbfff;
	// break/dead-time fields
	localparam int BRK_DT_LSB = 0;
	localparam int BRK_LOCK_LSB = 8;
	localparam int BRK_IDLE_OFFSTATE_SELECT_POS = 10;
	localparam int BRK_RUN_OFFSTATE_SELECT_POS = 11;
	localparam int BRK_MOE_POS = 15;
	localparam int BRK_IDLE_LSB = 16;
	localparam logic [31:0] BRK_USED_MASK = 32'h00ff_8fff;
	localparam logic [31:0] BRK_LOCK_MASK = 32'h0000_0300;
	localparam logic [1:0] LOCK_L2 = 2'h2;
	// trigger select
	localparam int TRIG_TS_LSB = 0;
	localparam logic [2:0] TS_INT_MAX = 3'h3;
	// channel direction codes
	localparam logic [1:0] DIR_OUT = 2'h0;
	localparam logic [1:0] DIR_IN_A = 2'h1;
	localparam logic [1:0] DIR_IN_B = 2'h2;
	localparam logic [1:0] DIR_TRC = 2'h3;
	// status fields
	localparam int STAT_DRV_LSB = 0;
	localparam int STAT_CDRV_LSB = 4;
	localparam int STAT_SETTLED_POS = 8;
endpackage : tco_pkg

// ---- tco_channel_ctrl.sv ----
// Purpose: direction, enable/polarity and output-state control for four timer channels
// Assumes: APB slave with one wait state; compare_reference and internal_trigger_source on pclk
// Notes: dead-time counts pclk cycles; outputs lag register changes by one clock and compare_reference by two
// Functional notes
// - channel 3 direction: output, timer input three, timer input two, internal trigger.
// - internal trigger mapping works only when trigger select picks an internal input.
// - channel 2 direction: output, timer input two, timer input three, internal trigger.
// - direction field writes ignored while that channel's enable bit is set.
// - complementary polarity 0 gives active high, 1 gives active low.
// - complementary polarity read-only at protection level 2 or 3 for output channels.
// - complementary enable drives complementary output per enable and off-state settings.
// - main polarity 0 gives active high output, 1 active low.
// - input polarity 0 rising edge non-inverted, 1 falling edge inverted.
// - main polarity read-only at protection level 2 or 3, any direction.
// - main enable drives main output per master enable and off-state settings.
// - input channel enable permits or blocks capture events.
// - channel n fields at bits 4n..4n+3; bit 14 reserved.
// - master on, run off-state 0: disabled outputs undriven and zero.
// - master on, one output enabled: it equals reference xor polarity, driven.
// - both enabled: main follows reference, complement its inverse, with dead-time.
// - run off-state 1: disabled output shows polarity, driven if sibling enabled.
// - master off, idle off-state 1: outputs show polarity values, driven.
// - then after a dead-time outputs take their idle levels.
// - master off, idle off-state 0: outputs undriven, showing polarity values.
`timescale 1ns/10ps
module tco_channel_ctrl
	import tco_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] compare_reference,
	input wire logic timer_input_two,
	input wire logic timer_input_three,
	input wire logic internal_trigger_source,
	input wire logic [1:0] chan_low_is_output,
	output logic [3:0] main_out,
	output logic [3:0] main_pin_drive,
	output logic [3:0] comp_out,
	output logic [3:0] comp_pin_drive,
	output logic chan2_capture_in,
	output logic chan3_capture_in,
	output logic [1:0] capture_strobe,
	output logic [3:0] capture_permit
);
	logic [15:0] channel_pair_mode_config;
	logic [15:0] channel_output_enable_polarity;
	logic [31:0] break_deadtime_reg;
	logic [2:0] trigger_select;
	logic ti2_s1, ti2_s2, ti3_s1, ti3_s2;
	logic moe_q;
	logic [DT_W-1:0] off_cnt;
	logic off_settled;
	logic [3:0] ref_q;
	logic [DT_W-1:0] dt_cnt [4];

	// bus decode
	wire logic setup_cyc = psel & penable & ~pready;
	wire logic access = psel & penable & pready;
	wire logic hit_mode = paddr == OFF_MODE;
	wire logic hit_enpol = paddr == OFF_ENPOL;
	wire logic hit_brk = paddr == OFF_BRK;
	wire logic hit_trig = paddr == OFF_TRIG;
	wire logic hit_stat = paddr == OFF_STAT;
	wire logic mapped = hit_mode | hit_enpol | hit_brk | hit_trig | hit_stat;
	wire logic wr_en = access & pwrite & mapped;

	// configuration fields
	wire logic [1:0] chan2_direction_sel = channel_pair_mode_config[MODE_C2DIR_LSB +: 2];
	wire logic [1:0] chan3_direction_sel = channel_pair_mode_config[MODE_C3DIR_LSB +: 2];
	wire logic master_output_enable = break_deadtime_reg[BRK_MOE_POS];
	wire logic idle_offstate_select = break_deadtime_reg[BRK_IDLE_OFFSTATE_SELECT_POS];
	wire logic run_offstate_select = break_deadtime_reg[BRK_RUN_OFFSTATE_SELECT_POS];
	wire logic [1:0] lock_level = break_deadtime_reg[BRK_LOCK_LSB +: 2];
	wire logic [DT_W-1:0] dt_val = break_deadtime_reg[BRK_DT_LSB +: DT_W];
	wire logic lock_hi = lock_level >= LOCK_L2;
	wire logic trc_ok = trigger_select <= TS_INT_MAX;

	wire logic [3:0] ce, cne, cp, cnp, idle_lv, cidle_lv, is_out, dt_clear;
	wire logic [3:0] next_mo, next_md, next_co, next_cd;
	wire logic [15:0] enpol_wmask;
	assign is_out = {chan3_direction_sel == DIR_OUT, chan2_direction_sel == DIR_OUT, chan_low_is_output};

	genvar n;
	generate
		for (n = 0; n < 4; n++) begin : g_chan
			// field placement per channel
			assign ce[n] = channel_output_enable_polarity[ENPOL_STRIDE*n + ENPOL_EN_POS];
			assign cp[n] = channel_output_enable_polarity[ENPOL_STRIDE*n + ENPOL_POL_POS];
			assign cne[n] = channel_output_enable_polarity[ENPOL_STRIDE*n + ENPOL_CEN_POS];
			assign cnp[n] = channel_output_enable_polarity[ENPOL_STRIDE*n + ENPOL_CPOL_POS];
			assign idle_lv[n] = break_deadtime_reg[BRK_IDLE_LSB + 2*n];
			assign cidle_lv[n] = break_deadtime_reg[BRK_IDLE_LSB + 2*n + 1];
			// main polarity bits freeze under protection; complementary polarity bits freeze only on output channels
			assign enpol_wmask[ENPOL_STRIDE*n + ENPOL_EN_POS] = 1'b1;
			assign enpol_wmask[ENPOL_STRIDE*n + ENPOL_CEN_POS] = 1'b1;
			assign enpol_wmask[ENPOL_STRIDE*n + ENPOL_POL_POS] = ~lock_hi;
			assign enpol_wmask[ENPOL_STRIDE*n + ENPOL_CPOL_POS] = ~(lock_hi & is_out[n]);

			// dead-time: an edge of the reference blanks both outputs for dt_val cycles
			assign dt_clear[n] = dt_cnt[n] == '0;
			wire logic single_m = ref_q[n] ^ cp[n];
			wire logic single_c = ref_q[n] ^ cnp[n];
			wire logic both_m = (ref_q[n] & dt_clear[n]) ^ cp[n];
			wire logic both_c = (~ref_q[n] & dt_clear[n]) ^ cnp[n];
			wire logic run_mo = ce[n] ? (cne[n] ? both_m : single_m) : (run_offstate_select & cp[n]);
			wire logic run_co = cne[n] ? (ce[n] ? both_c : single_c) : (run_offstate_select & cnp[n]);
			wire logic run_md = ce[n] | (run_offstate_select & cne[n]);
			wire logic run_cd = cne[n] | (run_offstate_select & ce[n]);
			wire logic idle_sel = idle_offstate_select & off_settled;
			assign next_mo[n] = master_output_enable ? run_mo : (idle_sel ? idle_lv[n] : cp[n]);
			assign next_co[n] = master_output_enable ? run_co : (idle_sel ? cidle_lv[n] : cnp[n]);
			assign next_md[n] = master_output_enable ? run_md : idle_offstate_select;
			assign next_cd[n] = master_output_enable ? run_cd : idle_offstate_select;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ref_q[n] <= 1'b0;
					dt_cnt[n] <= '0;
				end else begin
					ref_q[n] <= compare_reference[n];
					if (compare_reference[n] != ref_q[n]) begin
						dt_cnt[n] <= dt_val;
					end else if (!dt_clear[n]) begin
						dt_cnt[n] <= dt_cnt[n] - 1'b1;
					end
				end
			end
		end
	endgenerate

	// register write data with protected fields held
	wire logic [15:0] mode_wmask = {6'h3f, {2{~ce[3]}}, 6'h3f, {2{~ce[2]}}};
	wire logic [15:0] next_mode = (channel_pair_mode_config & ~mode_wmask) | (pwdata[15:0] & mode_wmask);
	wire logic [15:0] next_enpol = ((channel_output_enable_polarity & ~enpol_wmask) | (pwdata[15:0] & enpol_wmask))
		& ENPOL_USED_MASK;
	wire logic [31:0] brk_wmask = BRK_USED_MASK & ~((lock_level != 2'h0) ? BRK_LOCK_MASK : 32'h0000_0000);
	wire logic [31:0] next_brk = (break_deadtime_reg & ~brk_wmask) | (pwdata & brk_wmask);

	wire logic [31:0] stat_word = {23'h000000, off_settled, comp_pin_drive, main_pin_drive};
	wire logic [31:0] rd_value = hit_mode ? {16'h0000, channel_pair_mode_config} :
		hit_enpol ? {16'h0000, channel_output_enable_polarity} :
		hit_brk ? break_deadtime_reg :
		hit_trig ? {29'h00000000, trigger_select} :
		hit_stat ? stat_word : 32'h0000_0000;

	// capture input selection
	wire logic c2_src = (chan2_direction_sel == DIR_IN_A) ? ti2_s2 :
		(chan2_direction_sel == DIR_IN_B) ? ti3_s2 :
		(chan2_direction_sel == DIR_TRC) ? (internal_trigger_source & trc_ok) : 1'b0;
	wire logic c3_src = (chan3_direction_sel == DIR_IN_A) ? ti3_s2 :
		(chan3_direction_sel == DIR_IN_B) ? ti2_s2 :
		(chan3_direction_sel == DIR_TRC) ? (internal_trigger_source & trc_ok) : 1'b0;
	wire logic c2_in = c2_src ^ cp[2];
	wire logic c3_in = c3_src ^ cp[3];

	// apb slave: answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup_cyc;
			pslverr <= setup_cyc & ~mapped;
			if (setup_cyc) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_value;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_pair_mode_config <= MODE_RST;
			channel_output_enable_polarity <= ENPOL_RST;
			break_deadtime_reg <= BRK_RST;
			trigger_select <= TRIG_RST;
		end else if (wr_en) begin
			if (hit_mode) begin
				channel_pair_mode_config <= next_mode;
			end
			if (hit_enpol) begin
				channel_output_enable_polarity <= next_enpol;
			end
			if (hit_brk) begin
				break_deadtime_reg <= next_brk;
			end
			if (hit_trig) begin
				trigger_select <= pwdata[TRIG_TS_LSB +: 3];
			end
		end
	end

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ti2_s1 <= 1'b0;
			ti2_s2 <= 1'b0;
			ti3_s1 <= 1'b0;
			ti3_s2 <= 1'b0;
		end else begin
			ti2_s1 <= timer_input_two;
			ti2_s2 <= ti2_s1;
			ti3_s1 <= timer_input_three;
			ti3_s2 <= ti3_s1;
		end
	end

	// capture path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan2_capture_in <= 1'b0;
			chan3_capture_in <= 1'b0;
			capture_strobe <= 2'h0;
			capture_permit <= 4'h0;
		end else begin
			chan2_capture_in <= c2_in;
			chan3_capture_in <= c3_in;
			capture_strobe[0] <= c2_in & ~chan2_capture_in & ce[2] & ~is_out[2];
			capture_strobe[1] <= c3_in & ~chan3_capture_in & ce[3] & ~is_out[3];
			capture_permit <= ce & ~is_out;
		end
	end

	// off-state dead-time after the master enable drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			moe_q <= 1'b0;
			off_cnt <= '0;
			off_settled <= 1'b0;
		end else begin
			moe_q <= master_output_enable;
			if (master_output_enable) begin
				off_cnt <= '0;
				off_settled <= 1'b0;
			end else if (moe_q) begin
				off_cnt <= dt_val;
			end else if (off_cnt != '0) begin
				off_cnt <= off_cnt - 1'b1;
			end else begin
				off_settled <= 1'b1;
			end
		end
	end

	// pin outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			main_out <= 4'h0;
			main_pin_drive <= 4'h0;
			comp_out <= 4'h0;
			comp_pin_drive <= 4'h0;
		end else begin
			main_out <= next_mo;
			main_pin_drive <= next_md;
			comp_out <= next_co;
			comp_pin_drive <= next_cd;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence moe_drop_s;
		$fell(master_output_enable) && idle_offstate_select;
	endsequence

	dir_lock_a: assert property (wr_en && hit_mode && ce[2] |=> $stable(chan2_direction_sel))
		else $error("channel 2 direction changed while enabled");
	c2_input_a: assert property (chan2_direction_sel == DIR_IN_A |=>
		chan2_capture_in == ($past(ti2_s2) ^ $past(cp[2])))
		else $error("channel 2 input not timer input two");
	c3_input_a: assert property (chan3_direction_sel == DIR_IN_B |=>
		chan3_capture_in == ($past(ti2_s2) ^ $past(cp[3])))
		else $error("channel 3 input not timer input two");
	trc_gate_a: assert property (chan3_direction_sel == DIR_TRC && !trc_ok |=>
		chan3_capture_in == $past(cp[3]))
		else $error("internal trigger passed without internal select");
	pol_lock_a: assert property (wr_en && hit_enpol && lock_hi |=> $stable(cp))
		else $error("main polarity written under lock");
	cpol_lock_a: assert property (wr_en && hit_enpol && lock_hi && is_out[0] |=> $stable(cnp[0]))
		else $error("complementary polarity written under lock");
	rsv_bit_a: assert property (wr_en && hit_enpol |=> channel_output_enable_polarity[14] == 1'b0)
		else $error("reserved enable bit set");
	run_off_a: assert property (master_output_enable && !run_offstate_select && !ce[0] |=>
		!main_pin_drive[0] && !main_out[0])
		else $error("disabled output driven");
	single_out_a: assert property (master_output_enable && ce[1] && !cne[1] |=>
		main_pin_drive[1] && main_out[1] == ($past(ref_q[1]) ^ $past(cp[1])))
		else $error("single output wrong");
	dt_blank_a: assert property (master_output_enable && ce[0] && cne[0] && $rose(ref_q[0]) && dt_val != '0 |=>
		main_out[0] == $past(cp[0]) && comp_out[0] == $past(cnp[0]))
		else $error("dead-time not inserted");
	sib_drive_a: assert property (master_output_enable && run_offstate_select && !ce[0] && cne[0] |=>
		main_pin_drive[0] && main_out[0] == $past(cp[0]))
		else $error("off-state output wrong");
	idle_entry_a: assert property (moe_drop_s |=> main_pin_drive == 4'hf && main_out == $past(cp))
		else $error("idle off-state not entered");
	idle_settle_a: assert property (moe_drop_s ##0 dt_val == '0 |-> ##2 off_settled)
		else $error("idle level not reached after dead-time");
	idle_level_a: assert property (off_settled && !master_output_enable && idle_offstate_select |=>
		main_out == $past(idle_lv) && comp_out == $past(cidle_lv))
		else $error("idle level not shown");
	idle_float_a: assert property (!master_output_enable && !idle_offstate_select |=>
		main_pin_drive == 4'h0 && comp_pin_drive == 4'h0 && main_out == $past(cp))
		else $error("outputs driven in idle off-state 0");

	// first access cycle of a transfer, before the answer
	sequence acc_first_s;
		psel && penable && !pready;
	endsequence

	// channel 2 input rises while capture is permitted
	sequence c2_rise_s;
		ce[2] && !is_out[2] && c2_in && !chan2_capture_in;
	endsequence

	// outputs running with disabled outputs released
	sequence run_on_s;
		master_output_enable && !run_offstate_select;
	endsequence

	// bus answer
	apb_ready_a: assert property (acc_first_s |=> pready)
		else $error("ready not raised in access phase");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held for two cycles");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error flag without ready");

	// direction and capture selection
	dir_lock3_a: assert property (wr_en && hit_mode && ce[3] |=> $stable(chan3_direction_sel))
		else $error("channel 3 direction changed while enabled");
	c2_alt_a: assert property (chan2_direction_sel == DIR_IN_B |=>
		chan2_capture_in == ($past(ti3_s2) ^ $past(cp[2])))
		else $error("channel 2 input not timer input three");
	c3_main_a: assert property (chan3_direction_sel == DIR_IN_A |=>
		chan3_capture_in == ($past(ti3_s2) ^ $past(cp[3])))
		else $error("channel 3 input not timer input three");
	c2_trc_a: assert property (chan2_direction_sel == DIR_TRC && trc_ok |=>
		chan2_capture_in == ($past(internal_trigger_source) ^ $past(cp[2])))
		else $error("channel 2 internal trigger not passed");
	c2_out_a: assert property (chan2_direction_sel == DIR_OUT |=>
		chan2_capture_in == $past(cp[2]))
		else $error("output channel 2 shows an input");

	// capture events
	c2_strobe_a: assert property (c2_rise_s |=> capture_strobe[0])
		else $error("channel 2 capture event lost");
	strobe_off_a: assert property (!ce[2] |=> !capture_strobe[0])
		else $error("channel 2 capture while disabled");
	strobe3_off_a: assert property (!ce[3] |=> !capture_strobe[1])
		else $error("channel 3 capture while disabled");

	// run-mode output states
	comp_single_a: assert property (master_output_enable && cne[2] && !ce[2] |=>
		comp_pin_drive[2] && comp_out[2] == ($past(ref_q[2]) ^ $past(cnp[2])))
		else $error("single complementary output wrong");
	comp_off_a: assert property (run_on_s ##0 !cne[1] |=>
		!comp_pin_drive[1] && !comp_out[1])
		else $error("disabled complementary output driven");
	both_run_a: assert property (master_output_enable && ce[0] && cne[0] && dt_clear[0] |=>
		main_out[0] == ($past(ref_q[0]) ^ $past(cp[0])) && comp_out[0] == (!$past(ref_q[0]) ^ $past(cnp[0])))
		else $error("complementary pair wrong after dead-time");
	comp3_off_a: assert property (run_on_s |=> !comp_pin_drive[3])
		else $error("channel 3 complementary output driven");

	// idle entry and protection
	idle_comp_a: assert property (moe_drop_s |=>
		comp_pin_drive == 4'hf && comp_out == $past(cnp))
		else $error("complementary idle off-state not entered");
	lock_hold_a: assert property (wr_en && hit_brk && lock_level != 2'h0 |=> $stable(lock_level))
		else $error("protection level changed after being set");
endmodule : tco_channel_ctrl

// ---- tco_pin_model.sv ----
// Purpose: far side of the channel block, the timer input pins and the output pads
// Assumes: requested input levels change just after a rising clock edge
// Notes: a pad that the block releases is pulled low
`timescale 1ns/10ps
module tco_pin_model (
	input wire logic pclk,
	input wire logic want_two,
	input wire logic want_three,
	input wire logic [3:0] main_out,
	input wire logic [3:0] main_pin_drive,
	input wire logic [3:0] comp_out,
	input wire logic [3:0] comp_pin_drive,
	output logic timer_input_two,
	output logic timer_input_three,
	output logic [3:0] main_pin,
	output logic [3:0] comp_pin
);
	initial begin
		timer_input_two = 1'b0;
		timer_input_three = 1'b0;
	end
	always @(posedge pclk) begin
		timer_input_two <= want_two;
		timer_input_three <= want_three;
	end
	// pull-down on released pads
	assign main_pin = main_out & main_pin_drive;
	assign comp_pin = comp_out & comp_pin_drive;
endmodule : tco_pin_model

// ---- tb.sv ----
// Purpose: self-checking bench for the timer channel output control block
// Assumes: dead-time zero except one blanking case, channels 0 and 1 configured as output
// Notes: output cases run from a table, register locks and capture paths by hand
`timescale 1ns/10ps
module tb;
	import tco_pkg::*;
	typedef struct packed {
		logic [3:0] nib;
		logic [31:0] brk;
		logic rf;
		logic [3:0] exp;
	} tco_row_s;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] compare_reference = 4'h0;
	logic internal_trigger_source = 1'b1;
	logic [1:0] chan_low_is_output = 2'h3;
	logic want_two = 1'b0;
	logic want_three = 1'b0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, timer_input_two, timer_input_three, chan2_capture_in, chan3_capture_in;
	logic [3:0] main_out, main_pin_drive, comp_out, comp_pin_drive, main_pin, comp_pin, capture_permit;
	logic [1:0] capture_strobe;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_strobe = 0;
	int s0;
	// {enable nibble, break word, reference, {main, main drive, comp, comp drive}}
	tco_row_s rows [8] = '{'{4'h0, 32'h8000, 1'b1, 4'h0}, '{4'h3, 32'h8000, 1'b1, 4'h4},
		'{4'hc, 32'h8000, 1'b0, 4'h3}, '{4'h5, 32'h8000, 1'b1, 4'hd}, '{4'h6, 32'h8800, 1'b1, 4'hf},
		'{4'h0, 32'h8800, 1'b1, 4'h0}, '{4'hb, 32'h0, 1'b1, 4'ha}, '{4'h9, 32'h1_0400, 1'b1, 4'hd}};

	always #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		if (capture_strobe[0] === 1'b1) begin
			n_strobe <= n_strobe + 1;
		end
	end

	tco_channel_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compare_reference(compare_reference), .timer_input_two(timer_input_two),
		.timer_input_three(timer_input_three), .internal_trigger_source(internal_trigger_source),
		.chan_low_is_output(chan_low_is_output), .main_out(main_out), .main_pin_drive(main_pin_drive),
		.comp_out(comp_out), .comp_pin_drive(comp_pin_drive), .chan2_capture_in(chan2_capture_in),
		.chan3_capture_in(chan3_capture_in), .capture_strobe(capture_strobe), .capture_permit(capture_permit));
	tco_pin_model pins_u (.pclk(pclk), .want_two(want_two), .want_three(want_three), .main_out(main_out),
		.main_pin_drive(main_pin_drive), .comp_out(comp_out), .comp_pin_drive(comp_pin_drive),
		.timer_input_two(timer_input_two), .timer_input_three(timer_input_three), .main_pin(main_pin),
		.comp_pin(comp_pin));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_mismatch++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask : rdchk

	task automatic settle;
		repeat (6) @(posedge pclk);
	endtask : settle

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	// whole run is a few hundred cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		test_done();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("enpol reset", OFF_ENPOL, 32'h0);
		rdchk("mode reset", OFF_MODE, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		foreach (rows[i]) begin
			wr(OFF_ENPOL, {28'h0, rows[i].nib});
			wr(OFF_BRK, rows[i].brk);
			compare_reference <= {3'h0, rows[i].rf};
			settle();
			chk("ch0 outputs", {28'h0, main_out[0], main_pin_drive[0], comp_out[0], comp_pin_drive[0]},
				{28'h0, rows[i].exp});
			chk("ch0 pins", {30'h0, main_pin[0], comp_pin[0]},
				{30'h0, rows[i].exp[3] & rows[i].exp[2], rows[i].exp[1] & rows[i].exp[0]});
		end
		$display("output table test done");
		compare_reference <= 4'h0;
		wr(OFF_BRK, 32'h8003);
		wr(OFF_ENPOL, 32'h5);
		settle();
		compare_reference <= 4'h1;
		repeat (3) @(posedge pclk);
		chk("dead-time blank", {28'h0, main_out[0], main_pin_drive[0], comp_out[0], comp_pin_drive[0]}, 32'h5);
		settle();
		chk("dead-time end", {28'h0, main_out[0], main_pin_drive[0], comp_out[0], comp_pin_drive[0]}, 32'hd);
		$display("dead-time test done");
		wr(OFF_BRK, 32'h8000);
		compare_reference <= 4'h0;
		wr(OFF_ENPOL, 32'hffff);
		rdchk("enpol layout", OFF_ENPOL, 32'hbfff);
		settle();
		chk("all outputs", {16'h0, main_out, main_pin_drive, comp_out, comp_pin_drive}, 32'hff07);
		wr(OFF_MODE, 32'h0101);
		rdchk("mode while enabled", OFF_MODE, 32'h0);
		$display("layout test done");
		want_two <= 1'b1;
		for (int c = 1; c <= 3; c++) begin
			wr(OFF_ENPOL, 32'h0);
			wr(OFF_MODE, 32'((c << 8) | c));
			wr(OFF_ENPOL, 32'h1100);
			settle();
			chk("capture inputs", {30'h0, chan3_capture_in, chan2_capture_in}, {30'h0, c != 1, c != 2});
			chk("permit", {28'h0, capture_permit}, 32'hc);
			if (c == 2) begin
				want_three <= 1'b1;
				settle();
				chk("ch2 from input three", {31'h0, chan2_capture_in}, 32'h1);
				want_three <= 1'b0;
			end
			if (c == 1) begin
				s0 = n_strobe;
				wr(OFF_ENPOL, 32'h1300);
				settle();
				chk("ch2 inverted", {31'h0, chan2_capture_in}, 32'h0);
				wr(OFF_ENPOL, 32'h1100);
				settle();
				chk("ch2 strobes", n_strobe - s0, 32'h1);
				wr(OFF_ENPOL, 32'h1000);
				want_two <= 1'b0;
				settle();
				want_two <= 1'b1;
				settle();
				chk("blocked strobes", n_strobe - s0, 32'h1);
				chk("permit off", {28'h0, capture_permit}, 32'h8);
			end
			if (c == 3) begin
				wr(OFF_TRIG, 32'h4);
				settle();
				chk("trigger not internal", {30'h0, chan3_capture_in, chan2_capture_in}, 32'h0);
				wr(OFF_TRIG, 32'h0);
			end
		end
		$display("direction test done");
		wr(OFF_BRK, 32'h200);
		wr(OFF_ENPOL, 32'h0a0a);
		rdchk("locked polarity", OFF_ENPOL, 32'h0800);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("break reset", OFF_BRK, 32'h0);
		rdchk("enpol second reset", OFF_ENPOL, 32'h0);
		$display("lock and reset test done");
		test_done();
	end
endmodule : tb
